// ==== src/rt_subaddress_buffer_manager.v ====
// Purpose: per-subaddress data buffer management for a 1553 remote terminal
// Assumes: one clock; RAM answers a read with data in the next cycle
// Notes: the protocol engine frames each message with start and end pulses
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rt_sa_buf_regs.vh"
module rt_subaddress_buffer_manager (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // register port
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   output wire irq_o,
   // protocol engine message framing
   input wire msg_start_i,
   input wire tx_i,
   input wire bcst_i,
   input wire [4:0] subaddr_i,
   input wire [15:0] desc_base_i,
   input wire msg_end_i,
   input wire msg_valid_i,
   input wire mode_code_int_i,
   input wire stack_roll_i,
   // protocol engine data words
   output wire word_ready_o,
   input wire word_req_i,
   input wire [15:0] word_wdata_i,
   output reg [15:0] word_rdata_o,
   output reg word_rvalid_o,
   // shared RAM port
   output reg [15:0] mem_addr_o,
   output reg [15:0] mem_wdata_o,
   output reg mem_wr_o,
   output reg mem_rd_o,
   input wire [15:0] mem_rdata_i
);

// sequencer states
localparam S_IDLE = 3'h0;
localparam S_RD_PTR = 3'h1;
localparam S_RD_CW = 3'h2;
localparam S_CAP_PTR = 3'h3;
localparam S_CAP_CW = 3'h4;
localparam S_ACTIVE = 3'h5;
localparam S_WB = 3'h6;

reg [2:0] state_reg; // sequencer state
reg [2:0] cfg_reg; // area, keep-on-invalid, broadcast split
reg [5:0] status_reg; // sticky events
reg [5:0] enable_reg; // interrupt enables
reg tx_reg; // message is transmit
reg use_bc_reg; // broadcast section in use
reg [4:0] sa_reg; // addressed subaddress
reg [15:0] desc_reg; // descriptor base of this message
reg [15:0] lut_addr_reg; // address of the pointer entry
reg [15:0] start_ptr_reg; // pointer as fetched
reg [15:0] cur_ptr_reg; // next data word address
reg [15:0] cw_reg; // subaddress control word
reg valid_reg; // message ended valid
reg rd_p1_reg; // transmit read in flight
reg rd_p2_reg; // transmit read data due
reg roll_pulse_reg; // circular wrap seen this cycle
reg [5:0] ev_set; // events this cycle
reg [15:0] sect_ofs; // lookup section offset
reg [15:0] lut_addr_next; // pointer entry address
wire [15:0] area_base; // active lookup area
wire [2:0] scheme; // scheme of this message
wire circ; // circular mode selected
wire dbl; // double buffering applies
wire [15:0] size_mask; // offset bits of circular buffer
wire [15:0] inc_ptr; // pointer plus one
wire [15:0] adv_ptr; // advanced pointer
wire wrap_now; // offset at its last word
wire do_word; // data word taken now
wire wb_write; // pointer is rewritten

// active area from config
assign area_base = cfg_reg[`CFG_AREA_B] ? `LUT_AREA_B : `LUT_AREA_A;

// section select from direction and broadcast
always @* begin
   if (tx_i) begin
      sect_ofs = `LUT_TX_OFS;
   end else if (bcst_i && cfg_reg[`CFG_BCST_SEP]) begin
      sect_ofs = `LUT_BCST_OFS;
   end else begin
      sect_ofs = `LUT_RX_OFS;
   end
   lut_addr_next = area_base + sect_ofs + {11'h000, subaddr_i};
end

// scheme field for this message direction
assign scheme = tx_reg ? cw_reg[`CW_TX_SCH] :
   (use_bc_reg ? cw_reg[`CW_BC_SCH] : cw_reg[`CW_RX_SCH]);
assign circ = (scheme != `SCH_SINGLE);
// double buffering is ignored on transmit
assign dbl = !circ && !tx_reg && cw_reg[`CW_DBL_EN];
// mask of 128 << (scheme-1) words, minus one
// the largest buffer is 8192 words, so the mask fits 13 bits
assign size_mask = circ ?
   (((`CIRC_MIN_MASK + 16'h0001) << (scheme - 3'h1)) - 16'h0001) :
   16'h0000;
// linear advance, used as is outside circular mode
assign inc_ptr = cur_ptr_reg + 16'h0001;
// keep bits above the size, increment offset modulo size
assign adv_ptr = circ ?
   ((cur_ptr_reg & ~size_mask) | (inc_ptr & size_mask)) : inc_ptr;
assign wrap_now = circ && ((cur_ptr_reg & size_mask) == size_mask);

// data phase open while the sequencer is active
assign word_ready_o = (state_reg == S_ACTIVE);
// a word is taken only while the data phase is open
assign do_word = word_ready_o && word_req_i;

// pointer write decision at message end
// in circular mode a transmit pointer always moves on, even after an error; single-buffer transmit never rewrites it
assign wb_write = circ ?
   (valid_reg || tx_reg || !cfg_reg[`CFG_KEEP_INVALID]) :
   (dbl && valid_reg);

// message sequencer and RAM port
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      state_reg <= S_IDLE;
      tx_reg <= 1'b0;
      use_bc_reg <= 1'b0;
      sa_reg <= 5'h00;
      desc_reg <= 16'h0000;
      lut_addr_reg <= 16'h0000;
      start_ptr_reg <= 16'h0000;
      cur_ptr_reg <= 16'h0000;
      cw_reg <= 16'h0000;
      valid_reg <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      roll_pulse_reg <= 1'b0;
   end else begin
      // strobes last one cycle by default
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      roll_pulse_reg <= 1'b0;
      case (state_reg)
         S_IDLE: begin
            // latch the framing; it may change once the message runs
            if (msg_start_i) begin
               tx_reg <= tx_i;
               use_bc_reg <= !tx_i && bcst_i && cfg_reg[`CFG_BCST_SEP];
               sa_reg <= subaddr_i;
               desc_reg <= desc_base_i;
               lut_addr_reg <= lut_addr_next;
               state_reg <= S_RD_PTR;
            end
         end
         S_RD_PTR: begin
            // fetch data block pointer
            mem_addr_o <= lut_addr_reg;
            mem_rd_o <= 1'b1;
            state_reg <= S_RD_CW;
         end
         S_RD_CW: begin
            // fetch control word of this subaddress
            mem_addr_o <= area_base + `LUT_CW_OFS + {11'h000, sa_reg};
            mem_rd_o <= 1'b1;
            state_reg <= S_CAP_PTR;
         end
         S_CAP_PTR: begin
            // pointer read answered now, keep it for the descriptor
            start_ptr_reg <= mem_rdata_i;
            cur_ptr_reg <= mem_rdata_i;
            state_reg <= S_CAP_CW;
         end
         S_CAP_CW: begin
            cw_reg <= mem_rdata_i;
            // copy lookup entry into descriptor
            mem_addr_o <= desc_reg + `DESC_PTR_OFS;
            mem_wdata_o <= start_ptr_reg;
            mem_wr_o <= 1'b1;
            state_reg <= S_ACTIVE;
         end
         S_ACTIVE: begin
            // message end wins over a word request in the same cycle
            if (msg_end_i) begin
               valid_reg <= msg_valid_i;
               state_reg <= S_WB;
            end else if (do_word) begin
               // store receive word or fetch transmit word
               mem_addr_o <= cur_ptr_reg;
               mem_wdata_o <= word_wdata_i;
               mem_wr_o <= !tx_reg;
               mem_rd_o <= tx_reg;
               cur_ptr_reg <= adv_ptr;
               roll_pulse_reg <= wrap_now;
            end
         end
         S_WB: begin
            // end, error and subaddress events of this message are raised while in this state
            if (wb_write) begin
               mem_addr_o <= lut_addr_reg;
               // swap blocks or continue contiguously
               mem_wdata_o <= circ ? cur_ptr_reg :
                  (start_ptr_reg ^ (16'h0001 << `DBL_TOGGLE_BIT));
               mem_wr_o <= 1'b1;
            end
            state_reg <= S_IDLE;
         end
         default: begin
            // unused codes fall back to idle
            state_reg <= S_IDLE;
         end
      endcase
   end
end

// transmit read data return, three cycles after the request
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      rd_p1_reg <= 1'b0;
      rd_p2_reg <= 1'b0;
      word_rdata_o <= 16'h0000;
      word_rvalid_o <= 1'b0;
   end else begin
      rd_p1_reg <= do_word && !msg_end_i && tx_reg;
      rd_p2_reg <= rd_p1_reg;
      word_rvalid_o <= rd_p2_reg;
      // data stay until the next transmit word replaces them
      if (rd_p2_reg) begin
         word_rdata_o <= mem_rdata_i;
      end
   end
end

// event sources
// engine pulses are taken as they come, one cycle each
always @* begin
   ev_set = 6'h00;
   ev_set[`EV_EOM] = (state_reg == S_WB);
   ev_set[`EV_MSG_ERR] = (state_reg == S_WB) && !valid_reg;
   ev_set[`EV_SA_INT] = (state_reg == S_WB) && cw_reg[`CW_SA_INT];
   ev_set[`EV_CIRC_ROLL] = roll_pulse_reg;
   ev_set[`EV_MODE_CODE] = mode_code_int_i;
   ev_set[`EV_STACK_ROLL] = stack_roll_i;
end

// registers: config, sticky status, clear, enable
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      cfg_reg <= `CFG_RESET;
      status_reg <= 6'h00;
      enable_reg <= `EN_RESET;
      reg_rdata_o <= 16'h0000;
   end else begin
      if (reg_wr_i && reg_addr_i == `REG_CONFIG) begin
         cfg_reg <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `REG_ENABLE) begin
         enable_reg <= reg_wdata_i[5:0];
      end
      // a new event wins over a clear in the same cycle
      if (reg_wr_i && reg_addr_i == `REG_CLEAR) begin
         status_reg <= (status_reg & ~reg_wdata_i[5:0]) | ev_set;
      end else begin
         status_reg <= status_reg | ev_set;
      end
      // read data stands only in the cycle after the strobe
      reg_rdata_o <= 16'h0000;
      // clear register and unmapped indices read as zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            `REG_CONFIG: reg_rdata_o <= {13'h0000, cfg_reg};
            `REG_STATUS: reg_rdata_o <= {10'h000, status_reg};
            `REG_ENABLE: reg_rdata_o <= {10'h000, enable_reg};
            default: reg_rdata_o <= 16'h0000;
         endcase
      end
   end
end

// level interrupt while an enabled event is pending
assign irq_o = |(status_reg & enable_reg);

endmodule

// ==== src/rt_sa_buf_regs.vh ====
// Purpose: constants for the subaddress buffer manager
// Assumes: 16-bit shared RAM words, word addressed
// Notes: register offsets are word indices on the plain register port
`ifndef RT_SA_BUF_REGS_VH
`define RT_SA_BUF_REGS_VH
// register port offsets
`define REG_CONFIG 4'h0
`define REG_STATUS 4'h1
`define REG_CLEAR 4'h2
`define REG_ENABLE 4'h3
// config bits
`define CFG_AREA_B 0
`define CFG_KEEP_INVALID 1
`define CFG_BCST_SEP 2
`define CFG_RESET 3'h0
// status / enable bit positions
`define EV_EOM 0
`define EV_MSG_ERR 1
`define EV_SA_INT 2
`define EV_CIRC_ROLL 3
`define EV_MODE_CODE 4
`define EV_STACK_ROLL 5
`define EV_WIDTH 6
`define EN_RESET 6'h00
// lookup table areas and sections
`define LUT_AREA_A 16'h0140
`define LUT_AREA_B 16'h01C0
`define LUT_RX_OFS 16'h0000
`define LUT_TX_OFS 16'h0020
`define LUT_BCST_OFS 16'h0040
`define LUT_CW_OFS 16'h0060
// descriptor word that receives the lookup entry
`define DESC_PTR_OFS 16'h0002
// subaddress control word fields
`define CW_TX_SCH 2:0
`define CW_RX_SCH 5:3
`define CW_BC_SCH 8:6
`define CW_SA_INT 14
`define CW_DBL_EN 15
// scheme codes, smallest circular buffer, double buffer toggle bit
`define SCH_SINGLE 3'h0
`define CIRC_MIN_MASK 16'h007F
`define DBL_TOGGLE_BIT 5
`endif

// ==== verification/shared_ram_model.sv ====
// Purpose: shared ram on the far side of the buffer manager
// Assumes: one access a cycle, read data in the next cycle
// Notes: outside the answer cycle the data bus toggles every cycle
`timescale 1ns/10ps
module shared_ram_model (
   input wire clk_i,
   input wire [15:0] addr_i, wdata_i,
   input wire wr_i, rd_i,
   output reg [15:0] rdata_o
);
   reg [15:0] mem [0:65535]; // word store, preloaded by the host side
   initial rdata_o = 16'h0000;
   // store a write; answer a read only in the following cycle
   always @(posedge clk_i) begin
      if (wr_i)
         mem[addr_i] <= wdata_i;
      rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
   end
endmodule

// ==== verification/rt_sa_buf_assertions.sv ====
// Purpose: port checks for the subaddress buffer manager
// Assumes: the engine holds tx_i steady through a message
// Notes: bound to the design top at the foot of this file
`timescale 1ns/10ps
module rt_sa_buf_checker (
   // clock, reset, register port
   input wire clk_i, rst_n_i, reg_wr_i, reg_rd_i, irq_o,
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i, reg_rdata_o,
   // engine and ram side
   input wire msg_start_i, tx_i, msg_end_i, word_ready_o, word_req_i,
   input wire word_rvalid_o, mem_wr_o, mem_rd_o,
   input wire [15:0] word_wdata_i, word_rdata_o, mem_addr_o, mem_rdata_i,
   input wire [15:0] mem_wdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // no data phase open and no ram strobe out
   wire idle = !word_ready_o && !mem_rd_o && !mem_wr_o;
   // a word accepted while the message is open
   wire take = word_ready_o && word_req_i && !msg_end_i;
   rd_data_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
      else $error("read data not zero outside the answer cycle");
   lut_fetch_a: assert property (msg_start_i && idle |-> ##2 (mem_rd_o
      && mem_addr_o >= 16'h0140 && mem_addr_o <= 16'h023F))
      else $error("message start did not fetch from a lookup area");
   desc_first_a: assert property ($rose(word_ready_o) |-> mem_wr_o)
      else $error("data phase opened without descriptor write");
   rx_store_a: assert property (take && !tx_i |=> mem_wr_o
      && mem_wdata_o == $past(word_wdata_i))
      else $error("receive word not stored");
   tx_fetch_a: assert property (take && tx_i |=> mem_rd_o ##2
      word_rvalid_o && word_rdata_o == $past(mem_rdata_i))
      else $error("transmit word not fetched");
   ready_drop_a: assert property (msg_end_i && word_ready_o |=> !word_ready_o)
      else $error("data phase still open after message end");
   strobe_excl_a: assert property (!(mem_wr_o && mem_rd_o))
      else $error("ram read and write at once");
   irq_mask_a: assert property (reg_wr_i && reg_addr_i == 4'h3
      && reg_wdata_i == 0 |=> !irq_o)
      else $error("interrupt high with all enables off");
   cover property (msg_start_i && idle);
   cover property (word_rvalid_o);
   cover property (irq_o);
endmodule
bind rt_subaddress_buffer_manager rt_sa_buf_checker i_chk (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .irq_o(irq_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .msg_start_i(msg_start_i), .tx_i(tx_i),
   .msg_end_i(msg_end_i), .word_ready_o(word_ready_o),
   .word_req_i(word_req_i), .word_rvalid_o(word_rvalid_o),
   .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o), .word_wdata_i(word_wdata_i),
   .mem_wdata_o(mem_wdata_o),
   .word_rdata_o(word_rdata_o), .mem_addr_o(mem_addr_o),
   .mem_rdata_i(mem_rdata_i));

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the subaddress buffer manager
// Assumes: ram model answers a read one cycle later
// Notes: lookup entries and data are preloaded into the ram model
`timescale 1ns/10ps
`include "rt_sa_buf_regs.vh"
module testbench;
   // design inputs
   reg clk_i, rst_n_i, reg_wr_i, reg_rd_i, msg_start_i, tx_i, bcst_i;
   reg msg_end_i, msg_valid_i, mode_code_int_i, stack_roll_i, word_req_i;
   reg [3:0] reg_addr_i;
   reg [4:0] subaddr_i, sa;
   reg [15:0] reg_wdata_i, desc_base_i, word_wdata_i, m;
   // design outputs
   wire [15:0] reg_rdata_o, word_rdata_o, mem_addr_o, mem_wdata_o, ram_q;
   wire irq_o, word_ready_o, word_rvalid_o, mem_wr_o, mem_rd_o;
   integer seed, error_cnt, checks_done, s, r;
   integer tk = 0; // transmit words handed back so far
   reg [15:0] dq [0:3]; // words of the current message
   rt_subaddress_buffer_manager i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
      .msg_start_i(msg_start_i), .tx_i(tx_i), .bcst_i(bcst_i),
      .subaddr_i(subaddr_i), .desc_base_i(desc_base_i), .msg_end_i(msg_end_i),
      .msg_valid_i(msg_valid_i), .mode_code_int_i(mode_code_int_i),
      .stack_roll_i(stack_roll_i), .word_ready_o(word_ready_o),
      .word_req_i(word_req_i), .word_wdata_i(word_wdata_i),
      .word_rdata_o(word_rdata_o), .word_rvalid_o(word_rvalid_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o),
      .mem_rd_o(mem_rd_o), .mem_rdata_i(ram_q));
   shared_ram_model i_ram (.clk_i(clk_i), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .wr_i(mem_wr_o), .rd_i(mem_rd_o), .rdata_o(ram_q));
   // clock, 10 ns period
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // count a compare, report a mismatch
   task chk(input [23:0] nm, input [15:0] v, e);
      begin
         checks_done = checks_done + 1;
         if (v !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, v);
         end
      end
   endtask
   // one-cycle register write, then one settling cycle
   task reg_wr(input [3:0] a, input [15:0] d);
      begin
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
         @(posedge clk_i);
         reg_wr_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   // one-cycle register read, data compared in the cycle after
   task reg_rd(input [3:0] a, input [15:0] e);
      begin
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge clk_i);
         reg_rd_i <= 1'b0;
         @(posedge clk_i);
         chk("reg", reg_rdata_o, e);
      end
   endtask
   // preload, run one four-word message, compare ram and status
   task run(input [15:0] ar, input t, v, input [15:0] cw, p, ep, es);
      reg [15:0] lut;
      integer i;
      integer tb;
      begin
         // broadcast has its own section when the bench drives bcst_i
         lut = ar + sa + (t ? `LUT_TX_OFS :
            (bcst_i ? `LUT_BCST_OFS : `LUT_RX_OFS));
         tb = tk;
         i_ram.mem[ar + `LUT_CW_OFS + sa] = cw;
         i_ram.mem[lut] = p;
         for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            dq[i] = r[15:0];
            i_ram.mem[(p & ~m) | ((p + i) & m)] = dq[i];
         end
         tx_i <= t;
         subaddr_i <= sa;
         desc_base_i <= 16'h0010;
         msg_start_i <= 1'b1;
         @(posedge clk_i);
         msg_start_i <= 1'b0;
         for (i = 0; i < 20 && !word_ready_o; i = i + 1)
            @(posedge clk_i);
         chk("rdy", word_ready_o, 16'h0001);
         for (i = 0; i < 4; i = i + 1) begin
            word_req_i <= 1'b1;
            word_wdata_i <= ~dq[i];
            @(posedge clk_i);
         end
         word_req_i <= 1'b0;
         msg_end_i <= 1'b1;
         msg_valid_i <= v;
         @(posedge clk_i);
         msg_end_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         chk("dsc", i_ram.mem[16'h0010 + `DESC_PTR_OFS], p);
         chk("ptr", i_ram.mem[lut], ep);
         r = tk - tb;
         chk("txn", r[15:0], t ? 16'h0004 : 16'h0000);
         for (i = 0; i < 4 && !t; i = i + 1)
            chk("dat", i_ram.mem[(p & ~m) | ((p + i) & m)], ~dq[i]);
         reg_rd(`REG_STATUS, es);
         reg_wr(`REG_CLEAR, 16'h003F);
      end
   endtask
   // transmit words handed back by the design, checked in order
   always @(posedge clk_i) begin
      if (word_rvalid_o === 1'b1) begin
         chk("txd", word_rdata_o, dq[tk[1:0]]);
         tk <= tk + 1;
      end
   end
   // print counts and verdict, end the run
   task wrap_up;
      begin
         $display("errors %0d checks %0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // watchdog against a hang
   initial begin
      #300000;
      error_cnt = error_cnt + 1;
      wrap_up;
   end
   // main sequence
   initial begin
      seed = 32'h29e6;
      error_cnt = 0;
      checks_done = 0;
      {reg_wr_i, reg_rd_i, msg_start_i, tx_i, bcst_i, msg_end_i} = 6'h00;
      {msg_valid_i, mode_code_int_i, stack_roll_i, word_req_i} = 4'h0;
      {reg_addr_i, subaddr_i, reg_wdata_i, desc_base_i, word_wdata_i} = 0;
      rst_n_i = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      reg_rd(`REG_STATUS, 16'h0000);
      reg_rd(`REG_ENABLE, 16'h0000);
      reg_rd(`REG_CLEAR, 16'h0000);
      reg_rd(4'hF, 16'h0000);
      // circular receive across the wrap point, every size
      for (s = 1; s < 8; s = s + 1) begin
         m = (16'h0080 << (s - 1)) - 16'h0001;
         r = $random(seed);
         sa = r[4:0];
         run(`LUT_AREA_A, 0, 1, s << 3, 16'h4000 + m - 1, 16'h4002, 16'h0009);
      end
      m = 16'h007F;
      // pointer preset so the rollover falls on the first word
      run(`LUT_AREA_A, 1, 1, 16'h0001, 16'h307F, 16'h3003, 16'h0009);
      bcst_i <= 1'b1;
      reg_wr(`REG_CONFIG, 16'h0004);
      run(`LUT_AREA_A, 0, 1, 16'h4040, 16'h6010, 16'h6014, 16'h0005);
      bcst_i <= 1'b0;
      reg_wr(`REG_CONFIG, 16'h0002);
      run(`LUT_AREA_A, 0, 0, 16'h0008, 16'h5000, 16'h5000, 16'h0003);
      reg_wr(`REG_CONFIG, 16'h0001);
      m = 16'h001F;
      run(`LUT_AREA_B, 0, 1, 16'h8000, 16'h0800, 16'h0820, 16'h0001);
      // host view: the block the pointer held before the swap holds the data
      r = i_ram.mem[`LUT_AREA_B + sa] ^ 16'h0020;
      chk("inb", i_ram.mem[r[15:0]], ~dq[0]);
      run(`LUT_AREA_B, 1, 1, 16'h8000, 16'h0900, 16'h0900, 16'h0001);
      // events straight from the engine, mask and clear
      mode_code_int_i <= 1'b1;
      stack_roll_i <= 1'b1;
      @(posedge clk_i);
      mode_code_int_i <= 1'b0;
      stack_roll_i <= 1'b0;
      reg_wr(`REG_ENABLE, 16'h0010);
      chk("irq", irq_o, 16'h0001);
      reg_wr(`REG_ENABLE, 16'h0000);
      chk("irq", irq_o, 16'h0000);
      reg_rd(`REG_STATUS, 16'h0030);
      reg_wr(`REG_CLEAR, 16'h0030);
      reg_rd(`REG_STATUS, 16'h0000);
      wrap_up;
   end
endmodule
